// ---- spi_peer.sv ----
module spi_peer (
  input  wire logic i_sck,
  input  wire logic i_mosi,
  input  wire logic i_miso,
  output logic      o_miso,
  output logic      o_sck,
  output logic      o_mosi
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] tx_q;
  logic [7:0] rx_q;
  logic [7:0] miso_q;
  initial begin
    tx_q = 8'h00;
    miso_q = 8'h00;
    rx_q = 8'h00;
    o_sck = 1'b0;
    o_mosi = 1'b0;
  end
  assign o_miso = tx_q[7];
  // Mode 0 responder: sample on rise, shift on fall
  always @(posedge i_sck) rx_q <= {rx_q[6:0], i_mosi};
  always @(negedge i_sck) tx_q <= {tx_q[6:0], ~tx_q[7]};
  // Mode 0 master, 64 ns clock; clock stands low between frames
  task automatic send(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      o_mosi = b[7-i];
      #32 o_sck = 1'b1;
      miso_q = {miso_q[6:0], i_miso};
      #32 o_sck = 1'b0;
    end
    o_mosi = ~o_mosi;
  endtask : send
endmodule : spi_peer

// ---- spi_sel_pkg.sv ----
package spi_sel_pkg;

  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] DATA_OFS = 8'h08;
  localparam logic [7:0] EVT_OFS  = 8'h0c;
  localparam logic [7:0] MASK_OFS = 8'h10;
  localparam logic [7:0] PCFG_OFS = 8'h14;

  localparam int CTRL_IE   = 7;
  localparam int CTRL_EN   = 6;
  localparam int CTRL_ORD  = 5;
  localparam int CTRL_MST  = 4;
  localparam int CTRL_CPOL = 3;
  localparam int CTRL_CPHA = 2;
  localparam int STAT_DONE = 7;
  localparam int STAT_WCOL = 6;
  localparam int STAT_DBL  = 0;
  localparam int EVT_DONE  = 0;
  localparam int EVT_FAULT = 1;
  localparam int EVT_WCOL  = 2;
  localparam int PCFG_MOSI = 0;
  localparam int PCFG_MISO = 1;
  localparam int PCFG_SCK  = 2;
  localparam int PCFG_SS   = 3;
  localparam int PCFG_LVL  = 4;
  localparam int PCFG_GIE  = 7;
  localparam int IN_MOSI   = 0;
  localparam int IN_MISO   = 1;
  localparam int IN_SCK    = 2;
  localparam int IN_SS     = 3;

  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] PCFG_RST = 8'h00;
  localparam logic [3:0] LAST_EDGE = 4'hf;

  // Half SCK period in clocks, normal speed; double speed halves it
  localparam logic [6:0] HALF_R0 = 7'h02;
  localparam logic [6:0] HALF_R1 = 7'h08;
  localparam logic [6:0] HALF_R2 = 7'h20;
  localparam logic [6:0] HALF_R3 = 7'h40;

  typedef struct packed {
    logic mosi;
    logic mosi_oe_n;
    logic miso;
    logic miso_oe_n;
    logic sck;
    logic sck_oe_n;
    logic ss;
    logic ss_oe_n;
  } pins_s;

  localparam pins_s PINS_RST = 8'h55;

  typedef struct packed {
    logic [7:0]  ctrl;
    logic        dbl;
    logic        done;
    logic        wcol;
    logic        armed;
    logic [7:0]  pcfg;
    logic [7:0]  tx;
    logic [7:0]  rx;
    logic [7:0]  rbuf;
    logic        busy;
    logic [3:0]  ecnt;
    logic [3:0]  bcnt;
    logic [6:0]  div;
    logic        sck_int;
    logic        sdo;
    logic [2:0]  evt;
    logic [2:0]  mask;
    logic [3:0]  s1;
    logic [3:0]  s2;
    logic        sck_p;
    pins_s       pin;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
  } state_s;

endpackage : spi_sel_pkg

// ---- spi_select_and_control.sv ----
// Our own choices: the APB slave port and the address map.
module spi_select_and_control
  import spi_sel_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic             o_irq,
  input  wire logic        i_mosi,
  input  wire logic        i_miso,
  input  wire logic        i_sck,
  input  wire logic        i_ss_n,
  output logic             o_mosi,
  output logic             o_mosi_oe_n,
  output logic             o_miso,
  output logic             o_miso_oe_n,
  output logic             o_sck,
  output logic             o_sck_oe_n,
  output logic             o_ss_n,
  output logic             o_ss_oe_n
);

  state_s q;
  state_s d;

  logic       setup;
  logic       wr;
  logic       rd;
  logic       en;
  logic       mst;
  logic       cpha;
  logic       ss_in;
  logic       fault;
  logic       m_tick;
  logic       s_edge;
  logic       edge_ev;
  logic       din;
  logic       md;
  logic       sl;
  logic       clr_flags;
  logic [2:0] set_ev;
  logic [6:0] half;

  function automatic logic [6:0] half_cycles(input logic [1:0] rate,
                                             input logic       dbl);
    logic [6:0] h;
    h = HALF_R0;
    case (rate)
      2'h0: h = HALF_R0;
      2'h1: h = HALF_R1;
      2'h2: h = HALF_R2;
      default: h = HALF_R3;
    endcase
    return dbl ? (h >> 1) : h;
  endfunction : half_cycles

  function automatic logic [2:0] bit_idx(input logic       lsb_first,
                                         input logic [3:0] n);
    return lsb_first ? n[2:0] : 3'h7 - n[2:0];
  endfunction : bit_idx

  always_comb begin
    d = q;
    set_ev = 3'h0;
    d.s1[IN_MOSI] = i_mosi;
    d.s1[IN_MISO] = i_miso;
    d.s1[IN_SCK]  = i_sck;
    d.s1[IN_SS]   = i_ss_n;
    d.s2 = q.s1;
    d.sck_p = q.s2[IN_SCK];
    en = q.ctrl[CTRL_EN];
    mst = q.ctrl[CTRL_MST];
    cpha = q.ctrl[CTRL_CPHA];
    ss_in = q.s2[IN_SS];
    half = half_cycles(q.ctrl[1:0], q.dbl);

    setup = i_psel & ~i_penable;
    wr = i_psel & i_penable & q.pready & i_pwrite;
    rd = i_psel & i_penable & q.pready & ~i_pwrite;
    d.pready = setup;
    d.pslverr = 1'b0;
    d.prdata = 32'h0;
    if (setup) begin
      if (i_paddr == CTRL_OFS) begin
        d.prdata[7:0] = q.ctrl;
      end else if (i_paddr == STAT_OFS) begin
        d.prdata[STAT_DONE] = q.done;
        d.prdata[STAT_WCOL] = q.wcol;
        d.prdata[STAT_DBL] = q.dbl;
      end else if (i_paddr == DATA_OFS) begin
        d.prdata[7:0] = q.rbuf;
      end else if (i_paddr == EVT_OFS) begin
        d.prdata[2:0] = q.evt;
      end else if (i_paddr == MASK_OFS) begin
        d.prdata[2:0] = q.mask;
      end else if (i_paddr == PCFG_OFS) begin
        d.prdata[7:0] = q.pcfg;
      end else begin
        d.pslverr = 1'b1;
      end
    end

    // Flag clear: status read with a flag up, then a data access
    clr_flags = q.armed & (rd | wr) & (i_paddr == DATA_OFS);
    if (clr_flags) begin
      d.done = 1'b0;
      d.wcol = 1'b0;
      d.armed = 1'b0;
    end
    if (rd && i_paddr == STAT_OFS && (q.done || q.wcol)) begin
      d.armed = 1'b1;
    end
    if (rd && i_paddr == EVT_OFS) begin
      d.evt = 3'h0;
    end

    if (wr) begin
      if (i_paddr == CTRL_OFS) begin
        d.ctrl = i_pwdata[7:0];
      end else if (i_paddr == STAT_OFS) begin
        d.dbl = i_pwdata[STAT_DBL];
      end else if (i_paddr == MASK_OFS) begin
        d.mask = i_pwdata[2:0];
      end else if (i_paddr == PCFG_OFS) begin
        d.pcfg = i_pwdata[7:0];
      end else if (i_paddr == DATA_OFS) begin
        if (q.busy || (en && !mst && !ss_in && q.ecnt != 4'h0)) begin
          d.wcol = 1'b1;
          set_ev[EVT_WCOL] = 1'b1;
        end else begin
          d.tx = i_pwdata[7:0];
          d.sdo = d.tx[bit_idx(q.ctrl[CTRL_ORD], 4'h0)];
          if (en && mst) begin
            d.busy = 1'b1;
            d.ecnt = 4'h0;
            d.bcnt = 4'h0;
            d.div = 7'h0;
          end
        end
      end
    end

    // Master clock generator
    m_tick = 1'b0;
    if (q.busy) begin
      if (q.div == half - 7'h1) begin
        d.div = 7'h0;
        d.sck_int = ~q.sck_int;
        m_tick = 1'b1;
      end else begin
        d.div = q.div + 7'h1;
      end
    end else begin
      d.sck_int = q.ctrl[CTRL_CPOL];
    end

    // Slave side edge detection on synchronised pins
    s_edge = en & ~mst & ~ss_in & (q.s2[IN_SCK] != q.sck_p);
    if (en && !mst && ss_in) begin
      d.ecnt = 4'h0;
      d.bcnt = 4'h0;
      d.sdo = q.tx[bit_idx(q.ctrl[CTRL_ORD], 4'h0)];
    end

    edge_ev = m_tick | s_edge;
    din = mst ? q.s2[IN_MISO] : q.s2[IN_MOSI];
    if (edge_ev) begin
      if (q.ecnt[0] == cpha) begin
        d.rx[bit_idx(q.ctrl[CTRL_ORD], q.bcnt)] = din;
        d.bcnt = q.bcnt + 4'h1;
      end else begin
        d.sdo = q.tx[bit_idx(q.ctrl[CTRL_ORD], q.bcnt)];
      end
      if (q.ecnt == LAST_EDGE) begin
        d.ecnt = 4'h0;
        d.bcnt = 4'h0;
        d.busy = 1'b0;
        d.rbuf = d.rx;
        d.done = 1'b1;
        set_ev[EVT_DONE] = 1'b1;
      end else begin
        d.ecnt = q.ecnt + 4'h1;
      end
    end

    // Another master pulls our input select low
    fault = en & mst & ~q.pcfg[PCFG_SS] & ~ss_in;
    if (fault) begin
      d.ctrl[CTRL_MST] = 1'b0;
      d.busy = 1'b0;
      d.ecnt = 4'h0;
      d.bcnt = 4'h0;
      d.done = 1'b1;
      set_ev[EVT_FAULT] = 1'b1;
    end
    if (!d.ctrl[CTRL_EN] || !d.ctrl[CTRL_MST]) begin
      d.busy = 1'b0;
    end
    d.evt = d.evt | set_ev;

    md = d.ctrl[CTRL_EN] & d.ctrl[CTRL_MST];
    sl = d.ctrl[CTRL_EN] & ~d.ctrl[CTRL_MST];
    d.pin.mosi = d.sdo;
    d.pin.mosi_oe_n = ~(md & d.pcfg[PCFG_MOSI]);
    d.pin.sck = d.sck_int;
    d.pin.sck_oe_n = ~(md & d.pcfg[PCFG_SCK]);
    d.pin.miso = d.sdo;
    d.pin.miso_oe_n = ~(sl & ~d.s2[IN_SS] & d.pcfg[PCFG_MISO]);
    d.pin.ss = d.pcfg[PCFG_LVL];
    d.pin.ss_oe_n = ~(d.pcfg[PCFG_SS] & ~sl);
    d.irq = d.pcfg[PCFG_GIE] &
            ((d.ctrl[CTRL_IE] & d.done) | (|(d.evt & d.mask)));
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= '0;
      q.ctrl <= CTRL_RST;
      q.pcfg <= PCFG_RST;
      q.pin <= PINS_RST;
      q.s1 <= 4'hf;
      q.s2 <= 4'hf;
    end else begin
      q <= d;
    end
  end

  assign o_prdata    = q.prdata;
  assign o_pready    = q.pready;
  assign o_pslverr   = q.pslverr;
  assign o_irq       = q.irq;
  assign o_mosi      = q.pin.mosi;
  assign o_mosi_oe_n = q.pin.mosi_oe_n;
  assign o_miso      = q.pin.miso;
  assign o_miso_oe_n = q.pin.miso_oe_n;
  assign o_sck       = q.pin.sck;
  assign o_sck_oe_n  = q.pin.sck_oe_n;
  assign o_ss_n      = q.pin.ss;
  assign o_ss_oe_n   = q.pin.ss_oe_n;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  logic slave_on;
  assign slave_on = q.ctrl[CTRL_EN] & ~q.ctrl[CTRL_MST];

  fault_drop_a: assert property (
    fault |=> !q.ctrl[CTRL_MST] && q.done)
    else $error("fall back did not clear master or set done");

  fault_pins_a: assert property (
    fault |=> o_mosi_oe_n && o_sck_oe_n && !q.busy)
    else $error("fall back left master pins driven");

  fault_irq_a: assert property (
    fault && q.pcfg[PCFG_GIE] && q.ctrl[CTRL_IE] && !wr |=> o_irq)
    else $error("fall back raised no interrupt");

  slave_ss_in_a: assert property (
    slave_on |-> o_ss_oe_n)
    else $error("slave drives its select pin");

  slave_miso_a: assert property (
    slave_on && !q.s2[IN_SS] |-> o_miso_oe_n == !q.pcfg[PCFG_MISO])
    else $error("selected slave MISO direction wrong");

  slave_idle_a: assert property (
    slave_on && q.s2[IN_SS] |-> o_miso_oe_n && o_mosi_oe_n && o_sck_oe_n)
    else $error("deselected slave drives a pin");

  slave_reset_a: assert property (
    slave_on && q.s2[IN_SS] |=> q.ecnt == 4'h0 && q.bcnt == 4'h0)
    else $error("slave counters not reset by select");

  ss_general_a: assert property (
    q.ctrl[CTRL_MST] && q.pcfg[PCFG_SS]
      |-> !o_ss_oe_n && o_ss_n == q.pcfg[PCFG_LVL])
    else $error("master select output not plain output");

  disabled_idle_a: assert property (
    !q.ctrl[CTRL_EN] |-> !q.busy && o_mosi_oe_n && o_sck_oe_n)
    else $error("disabled port is active");

  busy_master_a: assert property (
    q.busy |-> q.ctrl[CTRL_MST] && q.ctrl[CTRL_EN])
    else $error("transfer running outside master mode");

  irq_level_a: assert property (
    q.pcfg[PCFG_GIE] && q.ctrl[CTRL_IE] && q.done |-> o_irq)
    else $error("done flag not signalled");

  first_bit_a: assert property (
    $rose(q.busy) |-> q.sdo == (q.ctrl[CTRL_ORD] ? q.tx[0] : q.tx[7]))
    else $error("first bit has wrong order");

  done_set_a: assert property (
    edge_ev && q.ecnt == LAST_EDGE |=> q.done && q.ecnt == 4'h0)
    else $error("finished byte did not set done");

  slave_miso_val_a: assert property (
    slave_on && !o_miso_oe_n |-> o_miso == q.sdo)
    else $error("selected slave MISO not from shifter");

  slave_quiet_a: assert property (
    slave_on && q.s2[IN_SS] |=> $stable(q.rx) && $stable(q.rbuf))
    else $error("deselected slave took data");

  slave_pins_in_a: assert property (
    !q.ctrl[CTRL_MST] |-> o_mosi_oe_n && o_sck_oe_n)
    else $error("non master drives MOSI or SCK");

  fault_event_a: assert property (
    fault |=> q.evt[EVT_FAULT])
    else $error("fall back event not recorded");

  master_sck_a: assert property (
    q.ctrl[CTRL_EN] && q.ctrl[CTRL_MST] && q.pcfg[PCFG_SCK]
      |-> !o_sck_oe_n)
    else $error("enabled master does not drive SCK");

  irq_gated_a: assert property (
    !q.pcfg[PCFG_GIE] |-> !o_irq)
    else $error("interrupt raised while globally disabled");

  disabled_miso_a: assert property (
    !q.ctrl[CTRL_EN] |-> o_miso_oe_n)
    else $error("disabled port drives MISO");

  ss_input_a: assert property (
    q.ctrl[CTRL_MST] && !q.pcfg[PCFG_SS] |-> o_ss_oe_n)
    else $error("master drives select set as input");

  sync_chain_a: assert property (
    q.s2 == $past(q.s1))
    else $error("pin synchroniser skipped a stage");

  slave_done_a: assert property (
    s_edge && q.ecnt == LAST_EDGE |=> q.evt[EVT_DONE])
    else $error("slave byte end not recorded");

  master_xfer_c: cover property (m_tick && q.ecnt == LAST_EDGE);
  slave_xfer_c: cover property (s_edge && q.ecnt == LAST_EDGE);
  fall_back_c: cover property (fault ##1 o_irq);
  slave_select_c: cover property (slave_on && $fell(q.s2[IN_SS]));
  lsb_master_c: cover property (m_tick && q.ctrl[CTRL_ORD]);

endmodule : spi_select_and_control

// ---- tb_top.sv ----
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import spi_sel_pkg::*;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  pins_s       p;
  logic        ss_ext, p_miso, p_sck, p_mosi;
  int          errors, tests_run, cyc;
  wire logic   w_mosi = p.mosi_oe_n ? p_mosi : p.mosi;
  wire logic   w_miso = p.miso_oe_n ? p_miso : p.miso;
  wire logic   w_sck  = p.sck_oe_n ? p_sck : p.sck;
  wire logic   w_ss   = p.ss_oe_n ? ss_ext : p.ss;
  spi_select_and_control DUT (.i_clk(clk), .i_rst_n(rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_irq(irq), .i_mosi(w_mosi), .i_miso(w_miso),
    .i_sck(w_sck), .i_ss_n(w_ss), .o_mosi(p.mosi),
    .o_mosi_oe_n(p.mosi_oe_n), .o_miso(p.miso), .o_miso_oe_n(p.miso_oe_n),
    .o_sck(p.sck), .o_sck_oe_n(p.sck_oe_n), .o_ss_n(p.ss),
    .o_ss_oe_n(p.ss_oe_n));
  spi_peer peer (.i_sck(w_sck), .i_mosi(w_mosi), .i_miso(w_miso),
    .o_miso(p_miso),
    .o_sck(p_sck), .o_mosi(p_mosi));
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      summarize();
    end
  end
  task automatic summarize();
    if (errors == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  task automatic chk(input string s, input logic [31:0] g, x);
    tests_run++;
    if (g !== x) begin
      errors++;
      $display("Error %s expected %h seen %h", s, x, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rdc(input string s, input logic [7:0] a,
                     input logic [31:0] m, x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(s, r & m, x);
  endtask : rdc
  task automatic wirq();
    repeat (1200) if (irq !== 1'b1) @(posedge clk);
  endtask : wirq
  task automatic done_chk(input logic [31:0] x);
    wirq();
    chk("irq", 32'(irq), 32'h1);
    rdc("done", STAT_OFS, 32'h80, 32'h80);
    rdc("data", DATA_OFS, 32'hff, x);
    chk("irq_clr", 32'(irq), 32'h0);
  endtask : done_chk
  task automatic t_reset();
    logic [31:0] r;
    logic        e;
    chk("oe", 32'({p.mosi_oe_n, p.miso_oe_n, p.sck_oe_n}), 32'h7);
    rdc("ctrl_rst", CTRL_OFS, 32'hff, 32'h0);
    apb(1'b0, 8'h30, 32'h0, r, e);
    chk("slverr", 32'(e), 32'h1);
    wr(PCFG_OFS, 32'h85);
    wr(CTRL_OFS, 32'h93);
    wr(DATA_OFS, 32'h55);
    wirq();
    chk("no_xfer", 32'({irq, p.sck_oe_n}), 32'h1);
  endtask : t_reset
  task automatic t_master(input logic [7:0] c, pb, tx, erx, ep);
    peer.tx_q = pb;
    wr(PCFG_OFS, 32'h9d);
    wr(CTRL_OFS, 32'(c));
    chk("ss_out", 32'({p.ss_oe_n, p.ss}), 32'h1);
    wr(DATA_OFS, 32'(tx));
    done_chk(32'(erx));
    chk("peer_rx", 32'(peer.rx_q), 32'(ep));
    rdc("ctrl_kept", CTRL_OFS, 32'hff, 32'(c));
  endtask : t_master
  task automatic t_fall();
    wr(PCFG_OFS, 32'h85);
    wr(CTRL_OFS, 32'hd3);
    ss_ext <= 1'b0;
    repeat (8) @(posedge clk);
    chk("fall_oe", 32'({p.mosi_oe_n, p.sck_oe_n}), 32'h3);
    chk("fall_irq", 32'(irq), 32'h1);
    rdc("fall_ctrl", CTRL_OFS, 32'hff, 32'hc3);
    ss_ext <= 1'b1;
    rdc("fall_done", STAT_OFS, 32'h80, 32'h80);
    rdc("fall_data", DATA_OFS, 32'hff, 32'h48);
    chk("masked", 32'(irq), 32'h0);
    wr(MASK_OFS, 32'h2);
    chk("unmasked", 32'(irq), 32'h1);
    rdc("fall_evt", EVT_OFS, 32'h2, 32'h2);
    chk("evt_clr", 32'(irq), 32'h0);
    wr(CTRL_OFS, 32'hd3);
    rdc("resume", CTRL_OFS, 32'hff, 32'hd3);
    chk("resume_oe", 32'({p.mosi_oe_n, p.sck_oe_n}), 32'h0);
  endtask : t_fall
  task automatic t_slave();
    wr(PCFG_OFS, 32'h82);
    wr(CTRL_OFS, 32'hc0);
    wr(DATA_OFS, 32'h3c);
    chk("desel", 32'({p.miso_oe_n, p.ss_oe_n}), 32'h3);
    peer.send(8'h0f, 4);
    @(posedge clk);
    ss_ext <= 1'b0;
    repeat (4) @(posedge clk);
    chk("sel", 32'({p.miso_oe_n, p.ss_oe_n}), 32'h1);
    peer.send(8'ha0, 4);
    @(posedge clk);
    ss_ext <= 1'b1;
    repeat (4) @(posedge clk);
    ss_ext <= 1'b0;
    repeat (4) @(posedge clk);
    peer.send(8'h5a, 8);
    @(posedge clk);
    done_chk(32'h5a);
    chk("slave_tx", 32'(peer.miso_q), 32'h3c);
    ss_ext <= 1'b1;
  endtask : t_slave
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    ss_ext = 1'b1;
    errors = 0;
    tests_run = 0;
    cyc = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_master(8'hd3, 8'h3c, 8'ha5, 8'h3c, 8'ha5);
    t_master(8'hf3, 8'h12, 8'h0f, 8'h48, 8'hf0);
    t_fall();
    t_slave();
    summarize();
  end
endmodule : tb_top
